// file: verilog/host_port_pkg.sv
package host_port_pkg;
	// ---------------------------------------------------------------
	// bus geometry
	// ---------------------------------------------------------------
	localparam int DATA_W = 8; // host data bus width
	localparam int ADDR_W = 3; // register address lines
	localparam int REG_COUNT = 8; // registers per channel

	// ---------------------------------------------------------------
	// register locations and fields inside a channel
	// ---------------------------------------------------------------
	localparam logic [2:0] DIV_LOW_ADDR = 3'h0; // divisor_low, device_id_reg when divisor is zero
	localparam logic [2:0] DIV_HIGH_ADDR = 3'h1; // divisor_high, revision_reg when divisor is zero
	localparam logic [2:0] FRAC_ADDR = 3'h2; // fractional_divisor
	localparam logic [2:0] LINE_CTRL_ADDR = 3'h3; // line control, holds divisor access bit
	localparam int DIV_ACCESS_BIT = 7; // opens the divisor window
	localparam logic [7:0] DIV_LOW_RESET = 8'h01; // divisor defaults to one
	localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
	localparam logic [7:0] FRAC_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ---------------------------------------------------------------
	// bit positions of the pin vector fed to the synchroniser
	// ---------------------------------------------------------------
	localparam int PIN_ADDR = 0; // three address bits at 0..2
	localparam int PIN_DATA = 3; // eight data bits at 3..10
	localparam int PIN_RD_N = 11;
	localparam int PIN_WR_N = 12;
	localparam int PIN_CSA_N = 13;
	localparam int PIN_CSB_N = 14;
	localparam int PIN_DS_N = 15;
	localparam int PIN_RNW = 16;
	localparam int PIN_CHAN = 17;
	localparam int PIN_ISO = 18;
	localparam int PIN_STRAP = 19;
	localparam int PIN_RST = 20;
	localparam int PIN_W = 21;
	// idle pin levels: strobes, selects and read line high, strap high
	localparam logic [PIN_W-1:0] PIN_IDLE = 21'h9F800;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000; // 250 MHz
	localparam int RESET_MIN_PS = 40000; // 40 ns least reset pulse
	localparam int RESET_CYCLES = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_CNT_W = $clog2(RESET_CYCLES + 1);
endpackage

// file: verilog/channel_regs.sv
`timescale 1ns/100ps
// one channel's register set; each channel owns an instance
module channel_regs #(
	parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] REVISION = 8'h03 // arbitrary value
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic [7:0] line_control
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0][7:0] regs; // plain registers
		logic [7:0] div_low; // divisor_low
		logic [7:0] div_high; // divisor_high
		logic [7:0] frac; // fractional_divisor
	} chan_s;

	chan_s st;
	chan_s next_st;
	logic dlab;
	logic div_zero;

	// divisor window decode, shared by read and write paths
	function automatic logic div_hit(input logic [2:0] a, input logic open);
		div_hit = open && (a == host_port_pkg::DIV_LOW_ADDR || a == host_port_pkg::DIV_HIGH_ADDR
			|| a == host_port_pkg::FRAC_ADDR);
	endfunction

	assign dlab = st.regs[host_port_pkg::LINE_CTRL_ADDR][host_port_pkg::DIV_ACCESS_BIT];
	assign div_zero = (st.div_low == 8'h00) && (st.div_high == 8'h00);
	assign line_control = st.regs[host_port_pkg::LINE_CTRL_ADDR];

	// ---------------------------------------------------------------
	// read mux: identity shows only while the whole divisor is zero
	// ---------------------------------------------------------------
	always_comb begin
		rdata = st.regs[addr];
		if (div_hit(addr, dlab)) begin
			case (addr)
				host_port_pkg::DIV_LOW_ADDR: rdata = div_zero ? DEVICE_ID : st.div_low;
				host_port_pkg::DIV_HIGH_ADDR: rdata = div_zero ? REVISION : st.div_high;
				default: rdata = st.frac; // fraction plays no part in the id check
			endcase
		end
	end

	// next state: clear wins over any write landing in the same cycle
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.regs = '0;
			next_st.div_low = host_port_pkg::DIV_LOW_RESET;
			next_st.div_high = host_port_pkg::DIV_HIGH_RESET;
			next_st.frac = host_port_pkg::FRAC_RESET;
		end else if (wr_en) begin
			if (div_hit(addr, dlab)) begin
				case (addr)
					host_port_pkg::DIV_LOW_ADDR: next_st.div_low = wdata;
					host_port_pkg::DIV_HIGH_ADDR: next_st.div_high = wdata;
					default: next_st.frac = wdata;
				endcase
			end else begin
				next_st.regs[addr] = wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st.regs <= '0;
			st.div_low <= host_port_pkg::DIV_LOW_RESET;
			st.div_high <= host_port_pkg::DIV_HIGH_RESET;
			st.frac <= host_port_pkg::FRAC_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	id_readout_a: assert property (@(posedge clk) disable iff (reset)
		dlab && div_zero && addr == host_port_pkg::DIV_HIGH_ADDR |-> rdata == REVISION)
		else $error("revision not shown with zero divisor");
endmodule

// file: verilog/dual_uart_host_port.sv
`timescale 1ns/100ps
//Contract
// - 8 data bits, 3 address lines, strobes
// - bus cycles timed by host strobes only
// - shared data bus, separate channel registers
// - strap high strobe style, low rw style
// - strobe style: low select picks channel
// - rw style: select low, bit picks channel
// - channel bit ignored in strobe style
// - reset over 40 ns clears both channels
// - zero divisor shows id and revision
// - isolation request in sleep frees bus
// - reset polarity follows bus style strap
module dual_uart_host_port #(
	parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] REVISION = 8'h03 // arbitrary value
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] address,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic device_select_n,
	input wire logic read_not_write,
	input wire logic channel_address_bit,
	input wire logic bus_isolate_request,
	input wire logic bus_type_select,
	input wire logic reset_pin,
	input wire logic sleep_mode,
	output logic strobe_style,
	output logic channel_clear,
	output logic [7:0] chan_a_line_control,
	output logic [7:0] chan_b_line_control
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [host_port_pkg::PIN_W-1:0] s1; // first sync stage
		logic [host_port_pkg::PIN_W-1:0] s2; // second sync stage
		logic [host_port_pkg::PIN_W-1:0] s3; // third sync stage
		logic [host_port_pkg::PIN_W-1:0] pins; // filtered pin view
		logic [host_port_pkg::RESET_CNT_W-1:0] rst_cnt; // reset pulse length
		logic chan_clear; // channels held in reset
		logic wr_act; // a write cycle is open
		logic [2:0] w_addr; // address held from the open write
		logic [7:0] w_data; // data held from the open write
		logic w_a; // write targets channel A
		logic w_b; // write targets channel B
		logic wr_pulse; // one-cycle commit
		logic [7:0] data_out;
		logic data_oe;
	} port_s;

	port_s st;
	port_s next_st;
	logic [host_port_pkg::PIN_W-1:0] raw;
	logic strap;
	logic rst_lvl;
	logic iso;
	logic sel_a;
	logic sel_b;
	logic rd_act;
	logic wr_now;
	logic [7:0] rd_a;
	logic [7:0] rd_b;

	// ---------------------------------------------------------------
	// pin decode on the filtered view
	// ---------------------------------------------------------------
	assign raw = {reset_pin, bus_type_select, bus_isolate_request, channel_address_bit,
		read_not_write, device_select_n, chan_b_select_n, chan_a_select_n,
		write_strobe_n, read_strobe_n, data_in, address};
	assign strap = st.pins[host_port_pkg::PIN_STRAP];
	// reset pin is active high in strobe style, active low otherwise
	assign rst_lvl = strap ? st.pins[host_port_pkg::PIN_RST]
		: !st.pins[host_port_pkg::PIN_RST];
	assign iso = st.pins[host_port_pkg::PIN_ISO] && sleep_mode;

	// channel select per bus style; the channel bit only counts in rw style
	always_comb begin
		if (strap) begin
			sel_a = !st.pins[host_port_pkg::PIN_CSA_N];
			sel_b = !st.pins[host_port_pkg::PIN_CSB_N];
			rd_act = !st.pins[host_port_pkg::PIN_RD_N] && (sel_a || sel_b);
			wr_now = !st.pins[host_port_pkg::PIN_WR_N] && (sel_a || sel_b);
		end else begin
			sel_a = !st.pins[host_port_pkg::PIN_DS_N] && !st.pins[host_port_pkg::PIN_CHAN];
			sel_b = !st.pins[host_port_pkg::PIN_DS_N] && st.pins[host_port_pkg::PIN_CHAN];
			rd_act = (sel_a || sel_b) && st.pins[host_port_pkg::PIN_RNW];
			wr_now = (sel_a || sel_b) && !st.pins[host_port_pkg::PIN_RNW];
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		// three-stage sync; a bit moves only once stages two and three agree
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < host_port_pkg::PIN_W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.pins[i] = st.s3[i];
			end
		end
		// reset filter: clear only after the pin held long enough
		if (!rst_lvl) begin
			next_st.rst_cnt = '0;
			next_st.chan_clear = 1'b0;
		end else if (st.rst_cnt == host_port_pkg::RESET_CNT_W'(host_port_pkg::RESET_CYCLES - 1)) begin
			next_st.chan_clear = 1'b1;
		end else begin
			next_st.rst_cnt = st.rst_cnt + 1'b1;
		end
		// a write opens with the strobe and commits when it closes,
		// so data settled over the whole strobe is what gets stored
		next_st.wr_pulse = 1'b0;
		next_st.wr_act = wr_now && !iso;
		if (wr_now && !iso) begin
			next_st.w_addr = st.pins[host_port_pkg::PIN_ADDR +: 3];
			next_st.w_data = st.pins[host_port_pkg::PIN_DATA +: 8];
			next_st.w_a = sel_a;
			next_st.w_b = sel_b;
		end else if (st.wr_act && !iso) begin
			next_st.wr_pulse = 1'b1;
		end
		// reads drive while selected; both selected is the host's fault,
		// channel A wins then rather than mixing two channels
		next_st.data_oe = rd_act && !iso;
		next_st.data_out = sel_a ? rd_a : rd_b;
		if (!(rd_act && !iso)) begin
			next_st.data_out = 8'h00;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// pin view starts at idle levels, so no phantom select or
			// strobe is decoded while the synchroniser refills
			st <= '{s1: host_port_pkg::PIN_IDLE, s2: host_port_pkg::PIN_IDLE,
				s3: host_port_pkg::PIN_IDLE, pins: host_port_pkg::PIN_IDLE, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	channel_regs #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) chan_a (
		.clk(clk),
		.reset(reset),
		.clear(st.chan_clear),
		.wr_en(st.wr_pulse && st.w_a),
		.addr(st.wr_pulse ? st.w_addr : st.pins[host_port_pkg::PIN_ADDR +: 3]),
		.wdata(st.w_data),
		.rdata(rd_a),
		.line_control(chan_a_line_control)
	);

	channel_regs #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) chan_b (
		.clk(clk),
		.reset(reset),
		.clear(st.chan_clear),
		.wr_en(st.wr_pulse && st.w_b),
		.addr(st.wr_pulse ? st.w_addr : st.pins[host_port_pkg::PIN_ADDR +: 3]),
		.wdata(st.w_data),
		.rdata(rd_b),
		.line_control(chan_b_line_control)
	);

	assign data_out = st.data_out;
	assign data_oe = st.data_oe;
	assign strobe_style = st.pins[host_port_pkg::PIN_STRAP];
	assign channel_clear = st.chan_clear;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// last open cycle seen while not isolated, then the strobe is seen closed
	sequence write_close;
		st.wr_act && !iso ##1 !st.wr_act;
	endsequence

	write_commit_a: assert property (write_close |-> st.wr_pulse
		&& $past(st.wr_pulse) == 1'b0)
		else $error("closed write did not commit");
	pulse_single_a: assert property (st.wr_pulse |=> !st.wr_pulse)
		else $error("write commit longer than one cycle");
	isolate_bus_a: assert property (iso |=> !data_oe)
		else $error("bus driven while isolated");
	read_drive_a: assert property (rd_act && !iso |=> data_oe)
		else $error("selected read not driven");
	strobe_ignore_a: assert property (strap && !st.pins[host_port_pkg::PIN_CSA_N]
		&& st.pins[host_port_pkg::PIN_CSB_N] |-> sel_a && !sel_b)
		else $error("strobe style select wrong");
	rw_select_a: assert property (!strap && !st.pins[host_port_pkg::PIN_DS_N]
		&& st.pins[host_port_pkg::PIN_CHAN] |-> sel_b && !sel_a)
		else $error("rw style select wrong");
	reset_length_a: assert property ($rose(st.chan_clear) |->
		$past(rst_lvl, 1) && $past(rst_lvl, 10))
		else $error("channel clear on short reset pulse");
	reset_polarity_a: assert property (!strap && st.pins[host_port_pkg::PIN_RST]
		|=> !st.chan_clear)
		else $error("reset polarity ignores bus style");
	dual_write_a: assert property (st.wr_pulse && st.w_a && st.w_b
		&& st.w_addr == host_port_pkg::LINE_CTRL_ADDR && !st.chan_clear
		|=> chan_a_line_control == chan_b_line_control)
		else $error("dual-select write diverged");
endmodule

// file: bench/host_model.sv
`timescale 1ns/100ps
// host cpu on the 8-bit asynchronous bus; drives every pin of the port
module host_model (
	input wire logic clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic [2:0] address,
	output logic [7:0] data_in,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic chan_a_select_n,
	output logic chan_b_select_n,
	output logic device_select_n,
	output logic read_not_write,
	output logic channel_address_bit,
	output logic bus_type_select,
	output logic reset_pin,
	output logic sleep_mode,
	output logic bus_isolate_request
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// all selects and strobes inactive
	task automatic idle();
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		chan_a_select_n <= 1'b1;
		chan_b_select_n <= 1'b1;
		device_select_n <= 1'b1;
		read_not_write <= 1'b1;
	endtask

	// one read or write; pins held long past the three-flop filter
	task automatic xfer(input logic wr, input logic sel_a, input logic sel_b,
		input logic [2:0] a, input logic [7:0] d, output logic [7:0] q, output logic oe);
		sel_b = sel_b & (wr | ~sel_a); // a read never selects both
		@(posedge clk);
		address <= a;
		data_in <= wr ? d : ~data_in; // released bus keeps toggling
		if (bus_type_select) begin
			chan_a_select_n <= ~sel_a;
			chan_b_select_n <= ~sel_b;
			read_strobe_n <= wr;
			write_strobe_n <= ~wr;
			channel_address_bit <= sel_a; // junk, must be ignored
		end else begin
			device_select_n <= ~(sel_a | sel_b);
			channel_address_bit <= sel_b;
			read_not_write <= ~wr;
		end
		// cycle is framed by strobes alone, held well over the minimum
		repeat (10) @(posedge clk);
		@(negedge clk);
		q = data_out;
		oe = data_oe;
		@(posedge clk);
		idle();
		data_in <= ~data_in;
		repeat (10) @(posedge clk);
	endtask

	// strap, sleep, isolation and reset pin levels, then settle time
	task automatic mode(input logic strap, input logic slp, input logic iso, input logic rp);
		@(posedge clk);
		bus_type_select <= strap;
		sleep_mode <= slp;
		bus_isolate_request <= iso;
		reset_pin <= rp;
		repeat (10) @(posedge clk);
	endtask

	// flip the reset pin to its active level for n cycles
	task automatic pulse(input int n);
		@(posedge clk);
		reset_pin <= ~reset_pin;
		repeat (n) @(posedge clk);
		reset_pin <= ~reset_pin;
		repeat (12) @(posedge clk);
	endtask

	initial begin
		address <= 3'h0;
		data_in <= 8'h00;
		channel_address_bit <= 1'b0;
		bus_type_select <= 1'b1;
		reset_pin <= 1'b0;
		sleep_mode <= 1'b0;
		bus_isolate_request <= 1'b0;
		idle();
	end
endmodule

// file: bench/dual_uart_host_port_tb.sv
`timescale 1ns/100ps
module dual_uart_host_port_tb;
	logic clk;
	logic reset;
	logic [2:0] address;
	logic [7:0] data_in, data_out, q, la, lb;
	logic read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
	logic device_select_n, read_not_write, channel_address_bit, bus_isolate_request;
	logic bus_type_select, reset_pin, sleep_mode, data_oe, strobe_style, channel_clear;
	logic oe, seen_clear;
	int n_errors;
	int num_checks;
	localparam logic [7:0] ID_CODE = 8'h4B; // arbitrary value
	localparam logic [7:0] REV_CODE = 8'h02; // arbitrary value

	host_model host_u (.clk, .data_out, .data_oe, .address, .data_in, .read_strobe_n,
		.write_strobe_n, .chan_a_select_n, .chan_b_select_n, .device_select_n,
		.read_not_write, .channel_address_bit, .bus_type_select, .reset_pin,
		.sleep_mode, .bus_isolate_request);
	dual_uart_host_port #(.DEVICE_ID(ID_CODE), .REVISION(REV_CODE)) dut_u (.clk, .reset,
		.address, .data_in, .data_out, .data_oe, .read_strobe_n, .write_strobe_n,
		.chan_a_select_n, .chan_b_select_n, .device_select_n, .read_not_write,
		.channel_address_bit, .bus_isolate_request, .bus_type_select, .reset_pin,
		.sleep_mode, .strobe_style, .channel_clear, .chan_a_line_control(la),
		.chan_b_line_control(lb));

	always #2 clk = ~clk;
	// latch any clear so a pulse shorter than a task is still seen
	always @(posedge clk) if (channel_clear === 1'b1) seen_clear <= 1'b1;

	// ----------------------------------------
	// compares and bus shorthands
	// ----------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic wr(input logic a, input logic b, input logic [2:0] ad, input logic [7:0] d);
		host_u.xfer(1'b1, a, b, ad, d, q, oe);
	endtask
	task automatic rd(input logic a, input logic b, input logic [2:0] ad, input logic [7:0] e);
		host_u.xfer(1'b0, a, b, ad, 8'h00, q, oe);
		chk1("data_oe", 1'b1, oe);
		chk8("data_out", e, q);
	endtask
	task automatic conclude();
		$display("checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// separate selects, channel bit set the wrong way round
	task automatic s_select();
		wr(1'b0, 1'b1, 3'h7, 8'hC3);
		wr(1'b1, 1'b0, 3'h7, 8'h3C);
		rd(1'b0, 1'b1, 3'h7, 8'hC3);
		rd(1'b1, 1'b0, 3'h7, 8'h3C);
	endtask
	// dual-select write, then a write and a read with nothing selected
	task automatic s_dual();
		wr(1'b1, 1'b1, 3'h4, 8'h96);
		rd(1'b1, 1'b0, 3'h4, 8'h96);
		rd(1'b0, 1'b1, 3'h4, 8'h96);
		wr(1'b1, 1'b1, 3'h3, 8'h1B);
		chk8("line control a", 8'h1B, la);
		chk8("line control b", 8'h1B, lb);
		wr(1'b0, 1'b0, 3'h4, 8'h69);
		host_u.xfer(1'b0, 1'b0, 1'b0, 3'h4, 8'h00, q, oe);
		chk1("data_oe", 1'b0, oe);
		rd(1'b0, 1'b1, 3'h4, 8'h96);
	endtask
	// zero divisor exposes identity codes
	task automatic s_ident();
		wr(1'b1, 1'b0, 3'h3, 8'h80);
		chk8("line control a", 8'h80, la);
		wr(1'b1, 1'b0, 3'h0, 8'h00);
		wr(1'b1, 1'b0, 3'h1, 8'h00);
		rd(1'b1, 1'b0, 3'h0, ID_CODE);
		rd(1'b1, 1'b0, 3'h1, REV_CODE);
		wr(1'b1, 1'b0, 3'h3, 8'h00);
	endtask
	// isolation only with both sleep and request
	task automatic s_isolate();
		host_u.mode(1'b1, 1'b1, 1'b0, 1'b0);
		rd(1'b1, 1'b0, 3'h7, 8'h3C);
		host_u.mode(1'b1, 1'b1, 1'b1, 1'b0);
		host_u.xfer(1'b0, 1'b1, 1'b0, 3'h7, 8'h00, q, oe);
		chk1("data_oe", 1'b0, oe);
		wr(1'b1, 1'b0, 3'h7, 8'h11);
		host_u.mode(1'b1, 1'b0, 1'b0, 1'b0);
		rd(1'b1, 1'b0, 3'h7, 8'h3C);
	endtask
	// read/write-line style, reset pin now idles high
	task automatic s_rw();
		host_u.mode(1'b0, 1'b0, 1'b0, 1'b1);
		chk1("strobe_style", 1'b0, strobe_style);
		wr(1'b1, 1'b0, 3'h5, 8'h2D);
		wr(1'b0, 1'b1, 3'h5, 8'hD2);
		wr(1'b0, 1'b0, 3'h5, 8'hFF);
		rd(1'b1, 1'b0, 3'h5, 8'h2D);
		rd(1'b0, 1'b1, 3'h5, 8'hD2);
		wr(1'b1, 1'b0, 3'h3, 8'h03);
	endtask
	// a short low pulse is ignored, a long one clears both channels
	task automatic s_pin_reset();
		seen_clear = 1'b0;
		host_u.pulse(3);
		chk1("channel_clear", 1'b0, seen_clear);
		rd(1'b1, 1'b0, 3'h5, 8'h2D);
		host_u.pulse(20);
		chk1("channel_clear", 1'b1, seen_clear);
		chk8("line control a", host_port_pkg::REG_RESET, la);
		rd(1'b0, 1'b1, 3'h5, host_port_pkg::REG_RESET);
		host_u.mode(1'b1, 1'b0, 1'b0, 1'b0);
		wr(1'b1, 1'b0, 3'h7, 8'h5C);
		seen_clear = 1'b0;
		host_u.pulse(20);
		chk1("channel_clear", 1'b1, seen_clear);
		rd(1'b1, 1'b0, 3'h7, host_port_pkg::REG_RESET);
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		n_errors = 0;
		num_checks = 0;
		seen_clear = 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		chk1("data_oe", 1'b0, data_oe);
		chk8("line control b", host_port_pkg::REG_RESET, lb);
		chk1("strobe_style", 1'b1, strobe_style);
		s_select();
		s_dual();
		s_ident();
		s_isolate();
		s_rw();
		s_pin_reset();
		conclude();
	end
	// hang guard: running out counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule
